// ==== common/flash_host_pkg.sv ====
// Constants, register map and pin bundle for the parallel NOR flash host controller.
// Assumes a 20 MHz core clock and a flash whose pins are driven directly by this controller.
package flash_host_pkg;

  // Clock and flash timing, in ns as given, and the cycle counts derived from them
  localparam int unsigned T_CLK_NS = 50;
  localparam int unsigned T_ACC_NS = 70;    // Address-to-data access time
  localparam int unsigned T_WP_NS  = 35;    // Write strobe low width
  localparam int unsigned T_RP_NS  = 500;   // Reset pulse width
  localparam int unsigned T_HV_NS  = 4000;  // Settle time of an elevated pin voltage
  localparam logic [7:0] CYC_ACC  = 8'((T_ACC_NS + T_CLK_NS - 1) / T_CLK_NS);
  localparam logic [7:0] CYC_WP   = 8'((T_WP_NS + T_CLK_NS - 1) / T_CLK_NS);
  localparam logic [7:0] CYC_RP   = 8'((T_RP_NS + T_CLK_NS - 1) / T_CLK_NS);
  localparam logic [7:0] CYC_HV   = 8'((T_HV_NS + T_CLK_NS - 1) / T_CLK_NS);
  localparam logic [7:0] CYC_SYNC = 8'h03;  // Pin register plus two input flops

  // Register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_CMD    = 8'h04;
  localparam logic [7:0] REG_ADDR   = 8'h08;
  localparam logic [7:0] REG_WDATA  = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_RDATA  = 8'h14;
  localparam logic [7:0] REG_PROT   = 8'h18;

  // Field positions
  localparam int unsigned CTRL_WORD_BIT    = 0;  // 1 = word configuration
  localparam int unsigned CTRL_TOPBOOT_BIT = 1;  // 1 = top-boot group map
  localparam int unsigned CTRL_POLL_BIT    = 2;  // Reads are status polls
  localparam int unsigned ST_BUSY_BIT      = 0;
  localparam int unsigned ST_NEEDRST_BIT   = 1;
  localparam int unsigned ST_REFUSED_BIT   = 2;
  localparam int unsigned ST_TIMEOUT_BIT   = 3;
  localparam int unsigned ST_GROUP_LSB     = 8;
  localparam int unsigned TIMEOUT_DQ_BIT   = 5;  // timeout_status_bit on the data bus

  // Reset values
  localparam logic [2:0]  CTRL_RST = 3'h1;
  localparam logic [21:0] ADDR_RST = 22'h000000;
  localparam logic [15:0] DATA_RST = 16'h0000;

  // Protection group address pattern
  localparam logic [5:0]  BOOT_TOP_PFX = 6'h3f;
  localparam logic [5:0]  BOOT_BOT_PFX = 6'h00;
  localparam logic [4:0]  GRP_TOP_TAIL = 5'h0f;
  localparam logic [4:0]  GRP_BOT_MID  = 5'h08;
  localparam int unsigned NUM_GROUPS   = 24;

  // Operations launched through the command register
  typedef enum logic [2:0] {
    OP_READ      = 3'h0,
    OP_WRITE     = 3'h1,
    OP_HWRESET   = 3'h2,
    OP_PROTECT   = 3'h3,
    OP_UNPROTECT = 3'h4,
    OP_HVID_READ = 3'h5
  } flash_op_t;

  // Sequencer states, Gray along setup, active, recovery
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SETUP = 3'b001,
    ST_ACT   = 3'b011,
    ST_RECOV = 3'b010,
    ST_RESET = 3'b110
  } seq_state_t;

  // Flash control pins as one bundle
  typedef struct packed {
    logic [20:0] addr;        // Address pins, most significant first
    logic        ce_n;        // Chip select
    logic        oe_n;        // Output gate
    logic        we_n;        // Write strobe
    logic        reset_n;     // Reset pin at logic level
    logic        byte_n;      // Width select, high = word
    logic        a9_hv;       // Elevated id voltage on id_voltage_address_pin
    logic        reset_hv;    // Elevated id voltage on reset pin
  } flash_pins_t;

endpackage

// ==== rtl/flash_host_ctrl.sv ====
// Host-side controller that drives a parallel NOR flash through its pins.
// Assumes an external level shifter turns a9_hv / reset_hv into the elevated id voltage,
// and that software reaches the controller over a simple strobe register port.
//
// Function
// - Host issues reset command after timeout bit high or identification mode.
// - Programmer holds address pin nine elevated; bits six, one, zero select.
// - Protection check places sector address on top address bits.
// - Identification codes also reachable by command sequence, no high voltage.
// - Command write: write strobe and chip select low, output gate high.
// - Host holds reset pin elevated, then uses normal writes to protect.
// - Host protects every unprotected group before any unprotect write.
`timescale 1ns/1ps

module flash_host_ctrl
  import flash_host_pkg::*;
#(
  parameter logic [7:0] HV_SETTLE_CYC = CYC_HV,  // Elevated voltage settle, in cycles
  parameter logic [7:0] RESET_CYC     = CYC_RP   // Reset pulse length, in cycles
) (
  input  wire logic        core_clk_i,   // 20 MHz core clock
  input  wire logic        rst_i,        // Asynchronous reset, active high
  input  wire logic [7:0]  reg_addr_i,   // Register byte address
  input  wire logic [31:0] reg_wdata_i,  // Register write data
  input  wire logic        reg_wr_i,     // Write strobe
  input  wire logic        reg_rd_i,     // Read strobe
  output logic      [31:0] reg_rdata_o,  // Read data, cycle after the strobe
  output flash_pins_t      pins_o,       // Flash control pins
  output logic      [15:0] dq_o,         // Data pins, driven value
  output logic      [15:0] dq_oe_o,      // Data pins, output enable
  input  wire logic [15:0] dq_i          // Data pins, sampled value
);

  // Elaboration guard: zero counts would never leave their state
  if (HV_SETTLE_CYC == 8'h00 || RESET_CYC == 8'h00) begin : g_bad_param
    $error("flash_host_ctrl: cycle counts must be at least one");
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  // Software registers
  logic [2:0]      ctrl_q;
  logic [21:0]     addr_q;
  logic [15:0]     wdata_q;
  logic [15:0]     rdata_q;
  logic [23:0]     prot_q;
  logic            needrst_q;
  logic            refused_q;
  logic            timeout_q;
  logic [31:0]     reg_rdata_q;
  seq_state_t      state_q;
  seq_state_t      state_d;
  logic [7:0]      cnt_q;
  logic [7:0]      cnt_d;
  flash_op_t       op_q;
  flash_pins_t     pins_q;
  flash_pins_t     pins_d;
  logic [15:0]     dq_q;
  logic [15:0]     dq_oe_q;
  logic [15:0]     dq_d;
  logic [15:0]     dq_oe_d;
  logic [15:0]     dq_s1_q;
  logic [15:0]     dq_s2_q;
  logic            cmd_wr;
  logic            launch;
  logic            word_mode;
  logic            is_read;
  logic            is_hv_wr;
  logic            read_done;
  logic [20:0]     pin_addr;
  logic [4:0]      group;

  assign word_mode = ctrl_q[CTRL_WORD_BIT];
  assign cmd_wr    = reg_wr_i && (reg_addr_i == REG_CMD);
  // Unprotect only once every group has been protected first
  assign launch    = cmd_wr && (state_q == ST_IDLE) &&
                     !((flash_op_t'(reg_wdata_i[2:0]) == OP_UNPROTECT) && !(&prot_q));
  assign is_read   = (op_q == OP_READ) || (op_q == OP_HVID_READ);
  assign is_hv_wr  = (op_q == OP_PROTECT) || (op_q == OP_UNPROTECT);
  assign read_done = (state_q == ST_ACT) && (cnt_q == 8'h01) && is_read;

  // In byte mode the address register is a byte address whose bit 0 rides on DQ15
  assign pin_addr = word_mode ? addr_q[20:0] : addr_q[21:1];

  // Group of the current address: top or bottom boot map
  always_comb begin
    group = 5'h00;
    if (ctrl_q[CTRL_TOPBOOT_BIT]) begin
      if (pin_addr[20:15] == BOOT_TOP_PFX) begin
        group = 5'(5'h10 + {2'h0, pin_addr[14:12]});
      end else if (pin_addr[20:17] == 4'hf) begin
        group = GRP_TOP_TAIL;
      end else begin
        group = {1'b0, pin_addr[20:17]};
      end
    end else begin
      if (pin_addr[20:15] == BOOT_BOT_PFX) begin
        group = {2'h0, pin_addr[14:12]};
      end else if (pin_addr[20:17] == 4'h0) begin
        group = GRP_BOT_MID;
      end else begin
        group = 5'(GRP_BOT_MID + {1'b0, pin_addr[20:17]});
      end
    end
  end

  // Configuration, address and write data registers
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q  <= CTRL_RST;
      addr_q  <= ADDR_RST;
      wdata_q <= DATA_RST;
    end else if (reg_wr_i) begin
      if (reg_addr_i == REG_CTRL) begin
        ctrl_q <= reg_wdata_i[2:0];
      end
      if (reg_addr_i == REG_ADDR) begin
        addr_q <= reg_wdata_i[21:0];
      end
      if (reg_addr_i == REG_WDATA) begin
        wdata_q <= reg_wdata_i[15:0];
      end
    end
  end

  // Status flags; a hardware set in the same cycle as a clear wins
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      needrst_q <= 1'b0;
      refused_q <= 1'b0;
      timeout_q <= 1'b0;
    end else begin
      if (reg_wr_i && reg_addr_i == REG_STATUS && reg_wdata_i[ST_REFUSED_BIT]) begin
        refused_q <= 1'b0;
      end
      if (cmd_wr && !launch) begin
        refused_q <= 1'b1;
      end
      // A launched write operation or hardware reset counts as the way back to array reads; protect and unprotect do not
      if (launch && flash_op_t'(reg_wdata_i[2:0]) inside {OP_WRITE, OP_HWRESET}) begin
        needrst_q <= 1'b0;
      end
      if (read_done) begin
        timeout_q <= dq_s2_q[TIMEOUT_DQ_BIT];
        // Timeout bit in a poll, or any id read, leaves the flash off array reads
        if ((ctrl_q[CTRL_POLL_BIT] && dq_s2_q[TIMEOUT_DQ_BIT]) || op_q == OP_HVID_READ) begin
          needrst_q <= 1'b1;
        end
      end
    end
  end

  // Read data capture and protection book-keeping
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= DATA_RST;
      prot_q  <= 24'h000000;
    end else begin
      if (read_done) begin
        rdata_q <= word_mode ? dq_s2_q : {8'h00, dq_s2_q[7:0]};
      end
      if (state_q == ST_ACT && cnt_q == 8'h01 && op_q == OP_PROTECT) begin
        prot_q[group] <= 1'b1;
      end
      if (state_q == ST_ACT && cnt_q == 8'h01 && op_q == OP_UNPROTECT) begin
        prot_q <= 24'h000000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  // Bus sequencer
  always_comb begin
    state_d = state_q;
    cnt_d   = (cnt_q == 8'h00) ? 8'h00 : 8'(cnt_q - 8'h01);
    unique case (state_q)
      ST_IDLE: begin
        if (launch && flash_op_t'(reg_wdata_i[2:0]) == OP_HWRESET) begin
          state_d = ST_RESET;
          cnt_d   = RESET_CYC;
        end else if (launch) begin
          state_d = ST_SETUP;
          // Elevated pins need settling before the first strobe
          cnt_d   = (flash_op_t'(reg_wdata_i[2:0]) inside {OP_PROTECT, OP_UNPROTECT,
                    OP_HVID_READ}) ? HV_SETTLE_CYC : 8'h01;
        end
      end
      ST_SETUP: begin
        if (cnt_q == 8'h01) begin
          state_d = ST_ACT;
          cnt_d   = is_read ? 8'(CYC_ACC + CYC_SYNC) : CYC_WP;
        end
      end
      ST_ACT: begin
        if (cnt_q == 8'h01) begin
          state_d = ST_RECOV;
          cnt_d   = 8'h01;
        end
      end
      ST_RECOV: begin
        if (cnt_q == 8'h01) begin
          state_d = ST_IDLE;
        end
      end
      ST_RESET: begin
        if (cnt_q == 8'h01) begin
          state_d = ST_RECOV;
          cnt_d   = 8'h01;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      cnt_q   <= 8'h00;
      op_q    <= OP_READ;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      if (launch) begin
        op_q <= flash_op_t'(reg_wdata_i[2:0]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  // Pin levels for the current state, registered before leaving the block
  always_comb begin
    pins_d          = '0;
    pins_d.addr     = pin_addr;
    pins_d.ce_n     = 1'b1;
    pins_d.oe_n     = 1'b1;
    pins_d.we_n     = 1'b1;
    pins_d.reset_n  = 1'b1;
    pins_d.byte_n   = word_mode;
    pins_d.a9_hv    = 1'b0;
    pins_d.reset_hv = 1'b0;
    dq_d            = wdata_q;
    dq_oe_d         = 16'h0000;
    if (state_q != ST_IDLE && is_hv_wr && state_q != ST_RESET) begin
      pins_d.reset_hv = 1'b1;
    end
    if (state_q != ST_IDLE && op_q == OP_HVID_READ && state_q != ST_RESET) begin
      pins_d.a9_hv = 1'b1;
    end
    if (state_q == ST_RESET) begin
      pins_d.reset_n = 1'b0;
    end else if (state_q == ST_SETUP || state_q == ST_ACT ||
                 (state_q == ST_RECOV && !is_read && op_q != OP_HWRESET)) begin
      pins_d.ce_n = 1'b0;
      if (is_read) begin
        pins_d.oe_n = 1'b0;
      end else begin
        // Command cycle: output gate stays high, strobe low only while active
        // Select and data hold one cycle past the strobe's rise, or the flash may miss them
        pins_d.we_n = (state_q != ST_ACT);
        dq_oe_d     = word_mode ? 16'hffff : 16'h00ff;
      end
    end
    // In byte mode DQ15 carries the lowest address bit at all times except during hardware reset
    if (!word_mode) begin
      dq_d[15]    = addr_q[0];
      dq_d[14:8]  = 7'h00;
      dq_oe_d[15] = (state_q != ST_RESET);
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pins_q  <= '{addr: 21'h000000, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, reset_n: 1'b1,
                   byte_n: 1'b1, a9_hv: 1'b0, reset_hv: 1'b0};
      dq_q    <= DATA_RST;
      dq_oe_q <= 16'h0000;
    end else begin
      pins_q  <= pins_d;
      dq_q    <= dq_d;
      dq_oe_q <= dq_oe_d;
    end
  end

  // Data pins come from outside the clock domain: two flops before use
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dq_s1_q <= 16'h0000;
      dq_s2_q <= 16'h0000;
    end else begin
      dq_s1_q <= dq_i;
      dq_s2_q <= dq_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  // Register read port; unmapped addresses read zero
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_q <= 32'h00000000;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        REG_CTRL:   reg_rdata_q <= {29'h0, ctrl_q};
        REG_ADDR:   reg_rdata_q <= {10'h0, addr_q};
        REG_WDATA:  reg_rdata_q <= {16'h0, wdata_q};
        REG_STATUS: reg_rdata_q <= {19'h0, group, 4'h0, timeout_q, refused_q, needrst_q,
                                    (state_q != ST_IDLE)};
        REG_RDATA:  reg_rdata_q <= {16'h0, rdata_q};
        REG_PROT:   reg_rdata_q <= {8'h0, prot_q};
        default:    reg_rdata_q <= 32'h00000000;
      endcase
    end else begin
      reg_rdata_q <= 32'h00000000;
    end
  end

  assign reg_rdata_o = reg_rdata_q;
  assign pins_o      = pins_q;
  assign dq_o        = dq_q;
  assign dq_oe_o     = dq_oe_q;

endmodule // flash_host_ctrl

// ==== sim/flash_host_properties.sv ====
// Concurrent checks on the flash host controller's pins and data output enables.
// Assumes it is bound to flash_host_ctrl; its parameters follow the instance.
`timescale 1ns/1ps
module flash_host_properties
  import flash_host_pkg::*;
#(
  parameter logic [7:0] HV_SETTLE_CYC = CYC_HV,  // Settle cycles
  parameter logic [7:0] RESET_CYC     = CYC_RP   // Reset low cycles
) (
  input wire logic        core_clk_i,   // Clock
  input wire logic        rst_i,        // Reset
  input wire flash_pins_t pins_o,       // Flash pins
  input wire logic [15:0] dq_oe_o       // Data enable
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  //////////////////////////////////////////////////////////////////////////////
  // Cycles the reset pin stood low and the elevated reset stood high
  logic [15:0] rl_cnt_q;
  logic [15:0] hv_cnt_q;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rl_cnt_q <= 16'h0000;
      hv_cnt_q <= 16'h0000;
    end else begin
      rl_cnt_q <= pins_o.reset_n ? 16'h0000 : rl_cnt_q + 16'h0001;
      hv_cnt_q <= pins_o.reset_hv ? hv_cnt_q + 16'h0001 : 16'h0000;
    end
  end
  // A write strobe under a voltage that has already stood a cycle
  sequence s_hv_write;
    pins_o.reset_hv ##1 (pins_o.reset_hv && $fell(pins_o.we_n));
  endsequence
  sequence s_we_fall;
    $fell(pins_o.we_n) && !pins_o.reset_hv;
  endsequence
  a_cmd_strobe: assert property (!pins_o.we_n |-> !pins_o.ce_n && pins_o.oe_n)
    else $error("write strobe without select or with output gate low");
  a_write_pulse: assert property (s_we_fall |=> pins_o.we_n)
    else $error("write strobe longer than one cycle");
  a_hv_settle: assert property (s_hv_write |-> hv_cnt_q >= {8'h00, HV_SETTLE_CYC})
    else $error("write under elevated reset before settling");
  a_read_nodrive: assert property (!pins_o.oe_n |-> dq_oe_o[14:0] == 15'h0000)
    else $error("host drives data while output gate is low");
  a_reset_float: assert property (!pins_o.reset_n |-> dq_oe_o == 16'h0000)
    else $error("host drives data during hardware reset");
  a_reset_width: assert property ($rose(pins_o.reset_n) |-> rl_cnt_q >= {8'h00, RESET_CYC})
    else $error("reset pulse too short");
  a_byte_upper: assert property (!pins_o.byte_n |-> dq_oe_o[14:8] == 7'h00)
    else $error("upper data pins driven in byte mode");
  a_byte_addr: assert property ((!pins_o.byte_n && pins_o.reset_n)[*2] |-> dq_oe_o[15])
    else $error("lowest address pin not driven in byte mode");
  a_id_read: assert property (pins_o.a9_hv |-> pins_o.we_n && !pins_o.reset_hv)
    else $error("write or elevated reset during id read");
endmodule // flash_host_properties

bind flash_host_ctrl flash_host_properties #(
  .HV_SETTLE_CYC(HV_SETTLE_CYC),
  .RESET_CYC(RESET_CYC)
) i_flash_host_properties (
  .core_clk_i(core_clk_i),
  .rst_i(rst_i),
  .pins_o(pins_o),
  .dq_oe_o(dq_oe_o)
);

// ==== sim/flash_dev_model.sv ====
// Behavioural top-boot parallel NOR flash seen from its pins.
// Assumes the host drives the pin bundle; the data bus level is resolved here.
`timescale 1ns/1ps
module flash_dev_model
  import flash_host_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'h3c,  // Arbitrary value
  parameter logic [7:0] DEV_CODE   = 8'h4d   // Arbitrary value
) (
  input  wire flash_pins_t pins_i,    // Pins from the host
  input  wire logic [15:0] dq_drv_i,  // Host data drive
  input  wire logic [15:0] dq_oe_i,   // Host data enable
  output logic      [15:0] dq_o       // Resolved bus level
);
  logic [15:0] mem_q [16] = '{default: 16'h0000};
  logic [23:0] prot_q = 24'h000000;
  logic [4:0]  grp;
  logic [15:0] rd_data;
  logic [15:0] rd_mask;
  //////////////////////////////////////////////////////////////////////////////
  // Boot sectors alone, three sectors in group 15, four in the rest
  assign grp = (pins_i.addr[20:15] == 6'h3f) ? {2'b10, pins_i.addr[14:12]} :
               (pins_i.addr[20:17] == 4'hf) ? 5'h0f : {1'b0, pins_i.addr[20:17]};
  // Strobe release takes data, or changes protection under the elevated reset
  always @(posedge pins_i.we_n) begin
    if (!pins_i.ce_n && pins_i.oe_n) begin
      if (pins_i.reset_hv && pins_i.addr[1:0] == 2'b10) begin
        if (pins_i.addr[6]) prot_q <= 24'h000000;
        else prot_q[grp] <= 1'b1;
      end else if (pins_i.reset_n && !prot_q[grp]) begin
        mem_q[pins_i.addr[3:0]] <= pins_i.byte_n ? dq_o : {8'h00, dq_o[7:0]};
      end
    end
  end
  // No sleep latency: a new address shows new data at once
  always_comb begin
    rd_mask = pins_i.byte_n ? 16'hffff : 16'h00ff;
    if (pins_i.a9_hv) begin
      case (pins_i.addr[1:0])
        2'b00: rd_data = {8'h00, MAKER_CODE};
        2'b01: rd_data = {8'h00, DEV_CODE};
        default: rd_data = {15'h0000, prot_q[grp]};
      endcase
    end else begin
      rd_data = mem_q[pins_i.addr[3:0]];
    end
    if (pins_i.ce_n || pins_i.oe_n || !pins_i.we_n || !pins_i.reset_n) begin
      rd_mask = 16'h0000;
    end
    // Floating bits move with the address so a stale value never passes
    dq_o = (dq_oe_i & dq_drv_i) | (~dq_oe_i & rd_mask & rd_data) |
           (~dq_oe_i & ~rd_mask & (16'h5a5a ^ pins_i.addr[15:0]));
  end
endmodule // flash_dev_model

// ==== sim/flash_user_modes_protection_tb_top.sv ====
// Self-checking bench: host controller driving the behavioural flash model.
// Assumes short settle and reset counts; expectations follow from them.
`timescale 1ns/1ps
module flash_user_modes_protection_tb_top;
  import flash_host_pkg::*;
  localparam logic [7:0] MAKER = 8'h3c;  // Arbitrary value
  localparam logic [7:0] DEVID = 8'h4d;  // Arbitrary value
  logic        core_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  flash_pins_t pins;
  logic [15:0] dq_drv;
  logic [15:0] dq_oe;
  logic [15:0] dq_bus;
  int          n_errors = 0;
  int          checked = 0;
  logic [31:0] rv;
  flash_host_ctrl #(.HV_SETTLE_CYC(8'h04), .RESET_CYC(8'h03)) i_flash_host_ctrl (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .pins_o(pins), .dq_o(dq_drv), .dq_oe_o(dq_oe), .dq_i(dq_bus));
  flash_dev_model #(.MAKER_CODE(MAKER), .DEV_CODE(DEVID)) i_flash_dev_model (
    .pins_i(pins), .dq_drv_i(dq_drv), .dq_oe_i(dq_oe), .dq_o(dq_bus));
  //////////////////////////////////////////////////////////////////////////////
  initial forever #25 core_clk_i = ~core_clk_i;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  // Data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 rv = reg_rdata_o;
    if (m != 32'h0) chk(rv & m, exp);
  endtask
  // Launch an operation and poll busy under a bounded count
  task automatic op(input logic [2:0] c);
    wr(REG_CMD, {29'h0, c});
    for (int i = 0; i < 100; i++) begin
      rd_chk(REG_STATUS, 32'h0, 32'h0);
      if (rv[0] === 1'b0) break;
    end
    chk(rv & 32'h1, 32'h0);
  endtask
  task automatic report_and_stop;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_rw;
    rd_chk(REG_CTRL, {29'h0, CTRL_RST}, 32'h7);
    rd_chk(REG_STATUS, 32'h0, 32'hf);
    rd_chk(8'h1c, 32'h0, 32'hffffffff);
    wr(REG_ADDR, 32'h5);
    wr(REG_WDATA, 32'h1234a5c3);
    op(3'h1);
    op(3'h0);
    rd_chk(REG_RDATA, 32'ha5c3, 32'hffffffff);
    wr(REG_CTRL, 32'h0);
    wr(REG_ADDR, 32'h6);
    wr(REG_WDATA, 32'h77e1);
    op(3'h1);
    op(3'h0);
    rd_chk(REG_RDATA, 32'he1, 32'hffffffff);
    // Bit five of 0xe1 is set: seen in status, but only a poll asks for the reset command
    rd_chk(REG_STATUS, 32'h8, 32'ha);
    wr(REG_CTRL, 32'h4);
    op(3'h0);
    rd_chk(REG_STATUS, 32'ha, 32'ha);
    wr(REG_CTRL, 32'h3);
    op(3'h2);
    rd_chk(REG_STATUS, 32'h0, 32'h2);
  endtask
  task automatic t_id;
    wr(REG_ADDR, 32'h0);
    op(3'h5);
    rd_chk(REG_RDATA, {24'h0, MAKER}, 32'hffffffff);
    rd_chk(REG_STATUS, 32'h2, 32'h2);
    wr(REG_ADDR, 32'h1);
    op(3'h5);
    rd_chk(REG_RDATA, {24'h0, DEVID}, 32'hffffffff);
    op(3'h2);
    rd_chk(REG_STATUS, 32'h0, 32'h2);
    wr(REG_ADDR, 32'h5);
    op(3'h0);
    rd_chk(REG_RDATA, 32'ha5c3, 32'hffffffff);
  endtask
  task automatic t_prot;
    wr(REG_ADDR, 32'h1fd002);
    op(3'h3);
    rd_chk(REG_PROT, 32'h00200000, 32'hffffffff);
    op(3'h5);
    rd_chk(REG_RDATA, 32'h1, 32'hffffffff);
    op(3'h4);
    rd_chk(REG_STATUS, 32'h4, 32'h4);
    rd_chk(REG_PROT, 32'h00200000, 32'hffffffff);
    wr(REG_STATUS, 32'h4);
    rd_chk(REG_STATUS, 32'h0, 32'h4);
    // Protect every top-boot group, with A1=1 and A0=0, so that unprotect is accepted
    for (int g = 0; g < 24; g++) begin
      wr(REG_ADDR, (g < 15) ? 32'((g << 17) + 2) :
                   (g == 15) ? 32'h1e0002 : 32'(32'h1f8002 + ((g - 16) << 12)));
      op(3'h3);
    end
    rd_chk(REG_PROT, 32'h00ffffff, 32'hffffffff);
    wr(REG_ADDR, 32'h42);
    op(3'h4);
    rd_chk(REG_STATUS, 32'h0, 32'h4);
    rd_chk(REG_PROT, 32'h0, 32'hffffffff);
    wr(REG_ADDR, 32'h1fd002);
    op(3'h5);
    rd_chk(REG_RDATA, 32'h0, 32'hffffffff);
  endtask
  // Group of the current address for both boot variants
  task automatic t_groups;
    logic [20:0] ga [10] = '{21'h1fd000, 21'h1e0000, 21'h1ff000, 21'h010000, 21'h0,
                              21'h007000, 21'h008000, 21'h018000, 21'h1f0000, 21'h020000};
    logic [4:0]  gg [10] = '{5'd21, 5'd15, 5'd23, 5'd0, 5'd0, 5'd7, 5'd8, 5'd8, 5'd23, 5'd9};
    for (int i = 0; i < 10; i++) begin
      wr(REG_CTRL, (i < 4) ? 32'h3 : 32'h1);
      wr(REG_ADDR, {11'h0, ga[i]});
      rd_chk(REG_STATUS, {19'h0, gg[i], 8'h0}, 32'h1f00);
    end
  endtask
  initial begin
    repeat (8) @(posedge core_clk_i);
    rst_i <= 1'b0;
    t_rw();
    t_id();
    t_prot();
    t_groups();
    report_and_stop();
  end
  // Watchdog well past the few hundred cycles the scenarios need
  initial begin
    repeat (20000) @(posedge core_clk_i);
    n_errors++;
    report_and_stop();
  end
endmodule // flash_user_modes_protection_tb_top
